//--- hdl/rtstr_regs.sv
/*
  Timer, supply selection, charger and frequency correction register bank.
  Assumes a same-clock byte register port from the serial-bus engine, a timer tick
  enable, and an oscillator tick enable; the supply comparator arrives asynchronously.
*/
`timescale 1ns/100ps
`default_nettype none

module rtstr_regs
  import rtstr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic timer_tick_i,
  input wire logic timer_run_i,
  input wire logic timer_repeat_i,
  input wire logic auto_use_backup_i,
  input wire logic vcc_below_bat_i,
  input wire logic [15:0] factory_trim_i,
  input wire logic osc_tick_i,
  input wire logic capture_i,
  input wire logic [6:0] capture_frac_i,
  output logic [7:0] reg_rdata_o,
  output logic use_backup_o,
  output logic charger_en_o,
  output logic [1:0] charger_res_o,
  output logic charger_diode_o,
  output logic [15:0] corr_word_o,
  output logic corr_add_o,
  output logic corr_drop_o
);
  logic [7:0] count_q, count_d;
  logic [7:0] reload_q, reload_d;
  logic [1:0] supply_q, supply_d;
  logic [3:0] charger_q, charger_d;
  logic [7:0] corr_hi_q, corr_hi_d;
  logic [7:0] corr_lo_q, corr_lo_d;
  logic written_q, written_d;
  logic [6:0] frac_q, frac_d;
  logic [7:0] rdata_d;
  logic use_backup_d;
  logic [15:0] corr_word_d;
  logic vcc_meta_q;
  logic vcc_below_q;

  function automatic logic wr_at(input logic [7:0] a);
    wr_at = reg_wr_i && (reg_addr_i == a);
  endfunction : wr_at

  // Resistance of the charging path; codes 0 and 1 both select the 3k path.
  function automatic logic [1:0] path_res(input logic [2:0] code);
    case (code[1:0])
      PATH_3K_A[1:0], PATH_3K_B[1:0]: path_res = RES_3K;
      PATH_6K[1:0]: path_res = RES_6K;
      default: path_res = RES_11K;
    endcase
  endfunction : path_res

  // The comparator is analog and unrelated to clk_i, so it is synchronised first.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vcc_meta_q <= 1'b0;
      vcc_below_q <= 1'b0;
    end
    else
    begin
      vcc_meta_q <= vcc_below_bat_i;
      vcc_below_q <= vcc_meta_q;
    end
  end

  always_comb
  begin
    count_d = count_q;
    if (timer_tick_i && timer_run_i)
    begin
      if (count_q != RESET_BYTE)
        count_d = count_q - 8'h01;
      else if (timer_repeat_i)
        count_d = reload_q;
    end
    // Host writes to the present count are dropped on purpose.
    reload_d = wr_at(ADDR_RELOAD) ? reg_wdata_i : reload_q;
    supply_d = wr_at(ADDR_SUPPLY) ? reg_wdata_i[1:0] : supply_q;
    charger_d = wr_at(ADDR_CHARGER) ? reg_wdata_i[3:0] : charger_q;
    corr_hi_d = wr_at(ADDR_CORR_HI) ? reg_wdata_i : corr_hi_q;
    corr_lo_d = wr_at(ADDR_CORR_LO) ? reg_wdata_i : corr_lo_q;
    written_d = written_q || wr_at(ADDR_CORR_HI) || wr_at(ADDR_CORR_LO);
    // A host write and a capture in one cycle: the capture wins, as it is an event.
    frac_d = frac_q;
    if (wr_at(ADDR_CAPTURE))
      frac_d = reg_wdata_i[CAPTURE_MSB:0];
    if (capture_i)
      frac_d = capture_frac_i;
    case (reg_addr_i)
      ADDR_COUNT: rdata_d = count_q;
      ADDR_RELOAD: rdata_d = reload_q;
      ADDR_SUPPLY: rdata_d = {6'h00, supply_q};
      ADDR_CHARGER: rdata_d = {4'h0, charger_q};
      ADDR_CORR_HI: rdata_d = corr_hi_q;
      ADDR_CORR_LO: rdata_d = corr_lo_q;
      ADDR_CAPTURE: rdata_d = {1'b0, frac_q};
      default: rdata_d = RESET_BYTE;
    endcase
    if (!reg_rd_i)
      rdata_d = reg_rdata_o;
    if (supply_q[SUPPLY_MANUAL_BIT])
      use_backup_d = supply_q[SUPPLY_BACKUP_BIT] && vcc_below_q;
    else
      use_backup_d = auto_use_backup_i;
    corr_word_d = written_q ? {corr_hi_q, corr_lo_q} : factory_trim_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      count_q <= RESET_BYTE;
      reload_q <= RESET_BYTE;
      supply_q <= 2'h0;
      charger_q <= 4'h0;
      corr_hi_q <= RESET_BYTE;
      corr_lo_q <= RESET_BYTE;
      written_q <= 1'b0;
      frac_q <= 7'h00;
      reg_rdata_o <= RESET_BYTE;
      use_backup_o <= 1'b0;
      charger_en_o <= 1'b0;
      charger_res_o <= RES_3K;
      charger_diode_o <= 1'b0;
      corr_word_o <= 16'h0000;
    end
    else
    begin
      count_q <= count_d;
      reload_q <= reload_d;
      supply_q <= supply_d;
      charger_q <= charger_d;
      corr_hi_q <= corr_hi_d;
      corr_lo_q <= corr_lo_d;
      written_q <= written_d;
      frac_q <= frac_d;
      reg_rdata_o <= rdata_d;
      use_backup_o <= use_backup_d;
      charger_en_o <= charger_q[CHARGER_EN_BIT];
      charger_res_o <= path_res(charger_q[3:1]);
      charger_diode_o <= charger_q[CHARGER_DIODE_BIT];
      corr_word_o <= corr_word_d;
    end
  end

  rtstr_trim u_trim (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .osc_tick_i(osc_tick_i),
    .word_i(corr_word_o),
    .add_o(corr_add_o),
    .drop_o(corr_drop_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_count_write;
    wr_at(ADDR_COUNT) && !(timer_tick_i && timer_run_i);
  endsequence
  sequence s_expire;
    timer_tick_i && timer_run_i && timer_repeat_i && count_q == 8'h00;
  endsequence
  sequence s_corr_lo_write;
    wr_at(ADDR_CORR_LO) ##1 !reg_wr_i;
  endsequence

  a_count_readonly: assert property (s_count_write |=> $stable(count_q))
    else $error("Host write changed the present count.");
  a_count_read: assert property (reg_rd_i && reg_addr_i == ADDR_COUNT && !timer_tick_i
      |=> reg_rdata_o == count_q)
    else $error("Count read did not return the live count.");
  a_timer_reload: assert property (s_expire |=> count_q == $past(reload_q))
    else $error("Timer did not reload in repeat mode.");
  a_auto_supply: assert property (!supply_q[0]
      |=> use_backup_o == $past(auto_use_backup_i))
    else $error("Automatic supply choice not followed.");
  a_manual_main: assert property (supply_q == 2'h1 |=> !use_backup_o)
    else $error("Manual main selection not followed.");
  a_backup_guard: assert property (supply_q[0] && !vcc_below_q |=> !use_backup_o)
    else $error("Backup chosen while main supply is higher.");
  a_manual_backup: assert property (supply_q == 2'h3 && vcc_below_q |=> use_backup_o)
    else $error("Manual backup request not honoured.");
  a_charger_path: assert property (wr_at(ADDR_CHARGER) ##1 !reg_wr_i
      |=> charger_en_o == $past(reg_wdata_i[0], 2) && charger_diode_o == $past(reg_wdata_i[3], 2))
    else $error("Charger settings did not follow the write.");
  a_corr_high: assert property (wr_at(ADDR_CORR_HI) ##1 !reg_wr_i
      |=> corr_word_o[15:8] == $past(reg_wdata_i, 2))
    else $error("Correction high byte not applied.");
  a_factory_trim: assert property (!written_q |=> corr_word_o == $past(factory_trim_i))
    else $error("Factory trim not used before the first write.");
  a_frac_msb: assert property (reg_rd_i && reg_addr_i == ADDR_CAPTURE
      |=> !reg_rdata_o[7])
    else $error("Capture bit 7 read as one.");
  a_reload_write: assert property (wr_at(ADDR_RELOAD)
      |=> reload_q == $past(reg_wdata_i))
    else $error("Reload register did not take the write.");
  a_count_step: assert property (timer_tick_i && timer_run_i && count_q != 8'h00
      |=> count_q == $past(count_q) - 8'h01)
    else $error("Present count did not step down on a tick.");
  a_tick_refused: assert property (timer_tick_i && !timer_run_i |=> $stable(count_q))
    else $error("Tick with the timer stopped changed the count.");
  a_timer_stop: assert property (timer_tick_i && timer_run_i && !timer_repeat_i
      && count_q == 8'h00 |=> count_q == 8'h00)
    else $error("Count left zero without repeat mode.");
  a_select_ignored: assert property (supply_q == 2'h2
      |=> use_backup_o == $past(auto_use_backup_i))
    else $error("Backup select acted with manual mode off.");
  a_corr_low: assert property (s_corr_lo_write
      |=> corr_word_o[7:0] == $past(reg_wdata_i, 2))
    else $error("Correction low byte not applied.");
  a_capture_load: assert property (capture_i |=> frac_q == $past(capture_frac_i))
    else $error("Capture strobe did not load the fraction bits.");
endmodule : rtstr_regs

`default_nettype wire

//--- include/rtstr_pkg.sv
/*
  Package for the timer, supply, charger and trim register bank of the RTC.
  Assumes a byte-wide register port fed by the serial-bus engine on the same clock.
*/
`default_nettype none

package rtstr_pkg;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_RELOAD = 8'h19;
  localparam logic [7:0] ADDR_SUPPLY = 8'h1A;
  localparam logic [7:0] ADDR_CHARGER = 8'h1B;
  localparam logic [7:0] ADDR_CORR_HI = 8'h1D;
  localparam logic [7:0] ADDR_CORR_LO = 8'h1E;
  localparam logic [7:0] ADDR_CAPTURE = 8'h20;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int SUPPLY_MANUAL_BIT = 0;
  localparam int SUPPLY_BACKUP_BIT = 1;
  localparam int CHARGER_EN_BIT = 0;
  localparam int CHARGER_PATH_LSB = 1;
  localparam int CHARGER_DIODE_BIT = 3;
  localparam int CAPTURE_MSB = 6;
  localparam logic [2:0] PATH_3K_A = 3'h0;
  localparam logic [2:0] PATH_3K_B = 3'h1;
  localparam logic [2:0] PATH_6K = 3'h2;
  localparam logic [1:0] RES_3K = 2'h0;
  localparam logic [1:0] RES_6K = 2'h1;
  localparam logic [1:0] RES_11K = 2'h2;
  // 2^-21 of a cycle is 0.4768 ppm, the step of one correction count.
  localparam int CORR_ACC_W = 21;
endpackage : rtstr_pkg

`default_nettype wire

//--- hdl/rtstr_trim.sv
/*
  Correction pulse generator: turns the signed correction word into add and drop pulses.
  Assumes osc_tick_i is a one-cycle enable at the oscillator rate on clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module rtstr_trim
  import rtstr_pkg::*;
#(
  parameter int ACC_W = CORR_ACC_W
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic osc_tick_i,
  input wire logic [15:0] word_i,
  output logic add_o,
  output logic drop_o
);
  logic [ACC_W:0] acc_q;
  logic [ACC_W:0] acc_d;
  logic add_d;
  logic drop_d;
  logic [15:0] mag;

  // The magnitude accumulates each tick; a carry out emits one pulse.
  always_comb
  begin
    mag = word_i[15] ? 16'(-word_i) : word_i;
    acc_d = {1'b0, acc_q[ACC_W-1:0]};
    add_d = 1'b0;
    drop_d = 1'b0;
    if (osc_tick_i)
    begin
      acc_d = {1'b0, acc_q[ACC_W-1:0]} + {{(ACC_W-15){1'b0}}, mag};
      add_d = acc_d[ACC_W] & ~word_i[15];
      drop_d = acc_d[ACC_W] & word_i[15];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      acc_q <= '0;
      add_o <= 1'b0;
      drop_o <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      add_o <= add_d;
      drop_o <= drop_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_pulse_excl: assert property (!(add_o && drop_o))
    else $error("Add and drop pulses at once.");
  a_zero_word: assert property (word_i == 16'h0000 |=> !add_o && !drop_o)
    else $error("Correction pulse with a zero word.");
  a_sign_dir: assert property (word_i[15] && $stable(word_i) |=> !add_o)
    else $error("Negative word produced an add pulse.");
endmodule : rtstr_trim

`default_nettype wire

//--- sim/rtstr_host.sv
/*
  Host model that reaches the register bank through its byte port.
  Assumes a free-running clk_i; it drives only at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module rtstr_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    // Idle lines show inverted values, so a stale address cannot pass for a live one.
    addr_o = ~a;
    wdata_o = ~d;
  endtask : put

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    @(negedge clk_i);
    d = rdata_i;
  endtask : rd
endmodule : rtstr_host

`default_nettype wire

//--- sim/rtstr_regs_test.sv
/*
  Self-checking bench for the register bank.
  Assumes the bank's byte port, with a host model driving it.
*/
`timescale 1ns/100ps
`default_nettype none

module rtstr_regs_test
  import rtstr_pkg::*;
;
  logic clk_i, rst_n_i, tick, run, rpt, auto_b, below, osc, cap;
  logic [6:0] frac;
  logic [15:0] trim;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd, use_b, chg_en, diode, add, drop;
  logic [1:0] res;
  logic [15:0] corr;
  int fail_count, checked, cyc;

  rtstr_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .timer_tick_i(tick), .timer_run_i(run),
    .timer_repeat_i(rpt), .auto_use_backup_i(auto_b), .vcc_below_bat_i(below),
    .factory_trim_i(trim), .osc_tick_i(osc), .capture_i(cap), .capture_frac_i(frac),
    .reg_rdata_o(rdata), .use_backup_o(use_b), .charger_en_o(chg_en),
    .charger_res_o(res), .charger_diode_o(diode), .corr_word_o(corr),
    .corr_add_o(add), .corr_drop_o(drop));
  rtstr_host host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // The run is well under a thousand cycles, so this ceiling only trips on a hang.
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, d});
  endtask : rdchk

  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt

  task automatic t_reset();
    logic [7:0] al[8] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h20, 8'h1C};
    chk("corr", trim, corr);
    chk("charger", 16'h0000, {chg_en, res, diode});
    foreach (al[i]) rdchk(al[i], 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_timer();
    host.put(ADDR_RELOAD, 8'h03, 1'b1);
    rdchk(ADDR_RELOAD, 8'h03);
    host.put(ADDR_COUNT, 8'hAA, 1'b1);
    rdchk(ADDR_COUNT, 8'h00);
    run = 1'b1;
    rpt = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      // The third tick arrives with the timer disabled and must be ignored.
      run = (i < 2);
      tick = 1'b1;
      wt(1);
      tick = 1'b0;
      rdchk(ADDR_COUNT, (i == 0) ? 8'h03 : 8'h02);
    end
    // Without repeat mode the count must rest at zero instead of reloading.
    rpt = 1'b0;
    run = 1'b1;
    tick = 1'b1;
    wt(3);
    tick = 1'b0;
    run = 1'b0;
    rdchk(ADDR_COUNT, 8'h00);
    $display("test timer done");
  endtask : t_timer

  task automatic t_supply();
    auto_b = 1'b1;
    wt(4);
    chk("auto", 16'h0001, use_b);
    auto_b = 1'b0;
    below = 1'b1;
    host.put(ADDR_SUPPLY, 8'h03, 1'b1);
    wt(4);
    chk("manual", 16'h0001, use_b);
    below = 1'b0;
    wt(4);
    chk("vcc high", 16'h0000, use_b);
    auto_b = 1'b1;
    below = 1'b1;
    host.put(ADDR_SUPPLY, 8'h01, 1'b1);
    wt(4);
    chk("main", 16'h0000, use_b);
    rdchk(ADDR_SUPPLY, 8'h01);
    auto_b = 1'b0;
    host.put(ADDR_SUPPLY, 8'h02, 1'b1);
    wt(4);
    chk("select only", 16'h0000, use_b);
    auto_b = 1'b1;
    wt(4);
    chk("auto again", 16'h0001, use_b);
    $display("test supply done");
  endtask : t_supply

  task automatic t_charger();
    logic [1:0] rl[4] = '{RES_3K, RES_3K, RES_6K, RES_11K};
    for (int i = 0; i < 9; i++)
    begin
      host.put(ADDR_CHARGER, (i < 8) ? {4'h0, i[2:0], 1'b1} : 8'h00, 1'b1);
      wt(2);
      chk("enable", (i < 8), chg_en);
      if (i < 8)
      begin
        chk("res", rl[i[1:0]], res);
        chk("diode", i[2], diode);
      end
    end
    $display("test charger done");
  endtask : t_charger

  task automatic t_corr(input logic [7:0] hi, input logic [7:0] lo, input int ea, input int ed);
    int na, nd;
    host.put(ADDR_CORR_HI, hi, 1'b1);
    host.put(ADDR_CORR_LO, lo, 1'b1);
    wt(2);
    chk("corr", {hi, lo}, corr);
    rdchk(ADDR_CORR_HI, hi);
    osc = 1'b1;
    for (int i = 0; i < 103; i++)
    begin
      osc = (i < 100);
      na += add;
      nd += drop;
      wt(1);
    end
    chk("add", 16'(ea), 16'(na));
    chk("drop", 16'(ed), 16'(nd));
    $display("test correction done");
  endtask : t_corr

  task automatic t_capture();
    frac = 7'h55;
    cap = 1'b1;
    wt(1);
    cap = 1'b0;
    rdchk(ADDR_CAPTURE, 8'h55);
    host.put(ADDR_CAPTURE, 8'hFF, 1'b1);
    rdchk(ADDR_CAPTURE, 8'h7F);
    $display("test capture done");
  endtask : t_capture

  initial
  begin
    {rst_n_i, tick, run, rpt, auto_b, below, osc, cap} = 8'h00;
    frac = 7'h00;
    trim = 16'h1234;
    wt(5);
    rst_n_i = 1'b1;
    wt(2);
    t_reset();
    t_timer();
    t_supply();
    t_charger();
    // At 2^-21 per step, 200 ticks of magnitude 0x7FFF carry three times in all.
    t_corr(8'h7F, 8'hFF, 1, 0);
    t_corr(8'h80, 8'h01, 0, 2);
    t_capture();
    wrap_up();
  end
endmodule : rtstr_regs_test

`default_nettype wire
